// ---- bench/tb_triggered_record_logger.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "trl_defs.svh"
module tb_triggered_record_logger;
   logic                 mclk;
   logic                 resetn;
   trl_pkg::axi_req_type axi_req;
   trl_pkg::axi_rsp_type axi_rsp;
   trl_pkg::tick_type    tick;
   logic [31:0]          alarm_in;
   logic [5:0]           din_in;
   trl_pkg::smp_type     smp;
   logic                 smp_ready;
   trl_pkg::rec_type     rec;
   logic                 rec_ready;
   logic                 log_full;
   logic [31:0]          got [0:18];
   logic [20:0]          last_idx;
   int                   n_rec;
   int                   fail_count;
   int                   n_compared;
   int                   p;
   logic [31:0]          rd;
   logic [1:0]           rsp;

   // Small capacity so wrap and full are reached in a short run
   triggered_record_logger #(.CAP_MAX(10), .CAP_STEP(1)) DUT (.mclk(mclk), .resetn(resetn), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .tick(tick), .alarm_in(alarm_in), .din_in(din_in), .smp(smp), .smp_ready(smp_ready),
      .rec(rec), .rec_ready(rec_ready), .log_full(log_full));
   trl_store_model store (.mclk(mclk), .resetn(resetn), .rec(rec), .rec_ready(rec_ready), .got(got),
      .last_idx(last_idx), .n_rec(n_rec));

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check

   task automatic bail;
      check(32'h0, 32'h1);
      test_done();
   endtask : bail

   // Ready lines stay high throughout, so every answer is taken when seen
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      axi_req.awaddr  <= a;
      axi_req.wdata   <= d;
      axi_req.wstrb   <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid  <= 1'b1;
      for (int i = 0; i < 100; i++)
      begin
         @(posedge mclk);
         if (axi_rsp.awready)
            axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready)
            axi_req.wvalid <= 1'b0;
         if (axi_rsp.bvalid)
         begin
            rsp = axi_rsp.bresp;
            return;
         end
      end
      bail();
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      axi_req.araddr  <= a;
      axi_req.arvalid <= 1'b1;
      for (int i = 0; i < 100; i++)
      begin
         @(posedge mclk);
         if (axi_rsp.arready)
            axi_req.arvalid <= 1'b0;
         if (axi_rsp.rvalid)
         begin
            rd  = axi_rsp.rdata;
            rsp = axi_rsp.rresp;
            return;
         end
      end
      bail();
   endtask : axi_rd

   // Valid is left high between samples; the caller lowers it after a batch
   task automatic put_smp(input logic [4:0] f, input logic [31:0] v, input logic fl1);
      smp <= '{1'b1, f, v, fl1, 1'b0};
      for (int i = 0; i < 200; i++)
      begin
         @(posedge mclk);
         if (smp_ready)
            return;
      end
      bail();
   endtask : put_smp

   task automatic pulse(input logic [7:0] t);
      tick <= t;
      @(posedge mclk);
      tick <= '0;
      @(posedge mclk);
   endtask : pulse

   task automatic wait_rec(input int n);
      for (int i = 0; i < 3000; i++)
      begin
         if (n_rec == n)
            return;
         @(posedge mclk);
      end
      bail();
   endtask : wait_rec

   task automatic quiet(input int n);
      repeat (200) @(posedge mclk);
      check(32'(n_rec), 32'(n));
   endtask : quiet

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial
   begin
      resetn = 1'b0;
      axi_req = '0;
      axi_req.bready = 1'b1;
      axi_req.rready = 1'b1;
      tick = '0;
      alarm_in = '0;
      din_in = '0;
      smp = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      axi_rd(`TRL_A_CTRL);
      check(rd, `TRL_CTRL_RST);
      axi_rd(`TRL_A_FCFG);
      check(rd, 32'h0);
      axi_rd(8'h20);
      check({30'h0, rsp}, {30'h0, `TRL_RESP_ERR});
      axi_wr(8'h20, 32'h1);
      check({30'h0, rsp}, {30'h0, `TRL_RESP_ERR});
      $display("test registers done");
      axi_wr(`TRL_A_FCFG + 8'h04, 32'h1);
      axi_wr(`TRL_A_FCFG + 8'h08, 32'h6);
      axi_wr(`TRL_A_CTRL, 32'h0000_00e5);
      put_smp(5'h0, 32'd10, 1'b0);
      put_smp(5'h0, 32'd20, 1'b0);
      put_smp(5'h1, 32'd7, 1'b0);
      put_smp(5'h1, 32'd3, 1'b0);
      put_smp(5'h2, 32'd2, 1'b0);
      put_smp(5'h2, 32'd6, 1'b1);
      smp.valid <= 1'b0;
      axi_wr(`TRL_A_CTRL, 32'h0001_00e5);
      wait_rec(1);
      check(got[0], 32'd15);
      check(got[1], 32'd7);
      check(got[2], 32'd6);
      check(32'(last_idx), 32'h0);
      $display("test manual capture done");
      axi_wr(`TRL_A_CTRL, 32'h0001_00e5);
      quiet(1);
      pulse(8'h80);
      wait_rec(2);
      check(got[0], 32'h0);
      check(got[2], 32'hffff_ffff);
      axi_rd(`TRL_A_WPTR);
      check(rd, 32'h2);
      $display("test second gate done");
      axi_wr(`TRL_A_RATE, 32'h0000_0001);
      for (p = 0; p < 7; p++)
      begin
         axi_wr(`TRL_A_CTRL, 32'h0000_0061 | (32'(p) << 11));
         pulse(8'h80);
         pulse(8'h40 >> p);
         wait_rec(3 + p);
         check(32'(last_idx), 32'(2 + p));
      end
      $display("test real time periods done");
      axi_wr(`TRL_A_AMASK, 32'h8000_0000);
      axi_wr(`TRL_A_CTRL, 32'h0000_0063);
      pulse(8'h80);
      alarm_in <= 32'h0000_0020;
      quiet(9);
      alarm_in <= 32'h8000_0020;
      wait_rec(10);
      pulse(8'h80);
      quiet(10);
      axi_rd(`TRL_A_WPTR);
      check(rd, 32'h0);
      check({31'h0, log_full}, 32'h1);
      alarm_in <= '0;
      $display("test alarm event and wrap done");
      axi_wr(`TRL_A_DMASK, 32'h0000_0020);
      axi_wr(`TRL_A_CTRL, 32'h0000_0074);
      din_in <= 6'h01;
      pulse(8'h80);
      quiet(10);
      din_in <= 6'h21;
      repeat (4) @(posedge mclk);
      pulse(8'h80);
      wait_rec(11);
      pulse(8'h80);
      wait_rec(12);
      din_in <= 6'h01;
      repeat (4) @(posedge mclk);
      pulse(8'h80);
      quiet(12);
      $display("test input level done");
      axi_wr(`TRL_A_CTRL, 32'h0000_007c);
      din_in <= 6'h21;
      repeat (4) @(posedge mclk);
      din_in <= 6'h01;
      pulse(8'h80);
      wait_rec(13);
      axi_wr(`TRL_A_CTRL, 32'h0002_007c);
      pulse(8'h80);
      quiet(13);
      axi_wr(`TRL_A_RATE, 32'h0001_0001);
      axi_wr(`TRL_A_CTRL, 32'h0000_0062);
      repeat (59) pulse(8'h80);
      quiet(13);
      pulse(8'h80);
      wait_rec(14);
      axi_wr(`TRL_A_RATE, 32'h0000_0001);
      axi_wr(`TRL_A_DUR, 32'h0000_0002);
      axi_wr(`TRL_A_CTRL, 32'h0000_006c);
      din_in <= 6'h21;
      repeat (4) @(posedge mclk);
      pulse(8'h80);
      wait_rec(15);
      pulse(8'h80);
      wait_rec(16);
      pulse(8'h80);
      quiet(16);
      $display("test latch, periodic and duration done");
      axi_wr(`TRL_A_CTRL, 32'h0000_0045);
      pulse(8'h80);
      axi_wr(`TRL_A_CTRL, 32'h0001_0045);
      quiet(16);
      $display("test stop on full done");
      test_done();
   end
endmodule : tb_triggered_record_logger
`default_nettype wire

// ---- bench/trl_store_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module trl_store_model (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire trl_pkg::rec_type rec,
   output var  logic             rec_ready,
   output var  logic [31:0]      got [0:18],
   output var  logic [20:0]      last_idx,
   output var  int               n_rec
);
   logic [1:0] cnt_q;
   // Storage takes three beats in four, so held beats are exercised
   assign rec_ready = (cnt_q != 2'h0);
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         cnt_q <= 2'h0;
         n_rec <= 0;
      end
      else
      begin
         cnt_q <= cnt_q + 2'h1;
         if (rec.valid && rec_ready)
         begin
            got[rec.field] <= rec.data;
            last_idx <= rec.index;
            if (rec.last)
               n_rec <= n_rec + 1;
         end
      end
   end
endmodule : trl_store_model
`default_nettype wire

// ---- rtl/triggered_record_logger.sv ----
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "trl_defs.svh"
// Contract
// - A record holds up to 19 values, count from the record size setting.
// - At most one record is started per real-time second.
// - Capacity runs 135,000 to 1.35 million records, shrinking with record size.
// - Archive interval period: one record at each interval end.
// - Minute or hour period: one record per clock rollover.
// - Contract day, week, month, year: one record per period boundary.
// - Wrap: at full, pointer returns to zero and overwrites.
// - Stop: at full, no further records are written.
// - Periodic mode: N records per second, minute, hour or day.
// - Alarm mode takes a 32-bit alarm select mask.
// - Alarm condition is the OR of selected active alarms.
// - Input mode takes a six-bit input select mask.
// - Input condition asserts when any selected input is high.
// - Event handling: one record per trigger occurrence.
// - Duration handling: periodic records for set seconds after the event.
// - Level handling: periodic records while the condition holds.
// - Latched handling: periodic records from event until release.
// - Manual mode: a remote request captures a record at once.
// - Each value is reduced as average, maximum or minimum.
// - Weighting defaults to none, else flow run one or two.
// - Weighted reduction uses only samples taken while that run flows.
module triggered_record_logger #(
   parameter int CAP_MAX  = `TRL_CAP_MAX,
   parameter int CAP_STEP = `TRL_CAP_STEP
) (
   input  wire logic                 mclk,
   input  wire logic                 resetn,
   input  wire trl_pkg::axi_req_type axi_req,
   output var  trl_pkg::axi_rsp_type axi_rsp,
   input  wire trl_pkg::tick_type    tick,
   input  wire logic [31:0]          alarm_in,
   input  wire logic [5:0]           din_in,
   input  wire trl_pkg::smp_type     smp,
   output var  logic                 smp_ready,
   output var  trl_pkg::rec_type     rec,
   input  wire logic                 rec_ready,
   output var  logic                 log_full
);
   trl_pkg::axi_rsp_type rsp_q;
   trl_pkg::rec_type     rec_q;
   trl_pkg::state_type   st_q, st_d;
   logic [7:0]  awa_q;
   logic        aw_q, w_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic [31:0] ctrl_q, rate_q, amask_q, dur_q;
   logic [5:0]  dmask_q;
   logic [3:0]  fcfg_q [19];
   logic [31:0] alm_s1_q, alm_s2_q;
   logic [5:0]  din_s1_q, din_s2_q;
   logic        cond_q, pend_q, sec_used_q, latch_q, full_q, rdy_q;
   logic        man_q, rel_q;
   logic [15:0] durc_q;
   logic [17:0] acc_q;
   logic [20:0] wptr_q;
   logic [4:0]  fld_q;
   logic [5:0]  step_q;
   logic [16:0] rem_q;
   logic [47:0] quo_q;
   logic [47:0] sum_q [19];
   logic [15:0] cnt_q [19];
   logic [31:0] max_q [19];
   logic [31:0] min_q [19];
   logic [31:0] last_q [19];

   // Register decode
   wire        wr_go = aw_q & w_q & ~rsp_q.bvalid;
   wire        rd_go = axi_req.arvalid & rsp_q.arready;
   wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   wire [31:0] wval_ctrl = (ctrl_q & ~wmask) | (wd_q & wmask);
   wire        fsel_w = (awa_q >= `TRL_A_FCFG) && (awa_q < 8'h8c);
   wire [4:0]  fidx_w = 5'((awa_q - `TRL_A_FCFG) >> 2);
   wire        fsel_r = (axi_req.araddr >= `TRL_A_FCFG) && (axi_req.araddr < 8'h8c);
   wire [4:0]  fidx_r = 5'((axi_req.araddr - `TRL_A_FCFG) >> 2);
   wire        wr_ok = fsel_w || awa_q <= `TRL_A_DUR;
   wire [31:0] stat_w = {27'h0, pend_q, st_q != trl_pkg::S_IDLE, latch_q, full_q, sec_used_q};

   // Configuration fields
   wire trl_pkg::mode_type mode = trl_pkg::mode_type'(ctrl_q[2:0]);
   wire trl_pkg::hand_type hand = trl_pkg::hand_type'(ctrl_q[4:3]);
   wire                    wrap = ctrl_q[5];
   wire [4:0]              rsz_raw = ctrl_q[10:6];
   wire trl_pkg::rtp_type  rtp = trl_pkg::rtp_type'(ctrl_q[13:11]);
   wire [4:0] rsz = (rsz_raw == 5'h0) ? 5'h1 : (rsz_raw > `TRL_NFLD) ? `TRL_NFLD : rsz_raw;
   wire [20:0] cap = 21'(CAP_MAX - int'(rsz - 5'h1) * CAP_STEP);

   // Periodic rate generator, fractional so no divider is needed
   wire [17:0] unit_s = (rate_q[17:16] == 2'h0) ? `TRL_SEC_S :
                        (rate_q[17:16] == 2'h1) ? `TRL_SEC_M :
                        (rate_q[17:16] == 2'h2) ? `TRL_SEC_H : `TRL_SEC_D;
   wire [17:0] acc_sum = acc_q + {2'h0, rate_q[15:0]};
   // Rates above one per second would let the leftover grow without end, so it is dropped
   wire [17:0] acc_left = 18'(acc_sum - unit_s);
   wire        per_hit = tick.sec && rate_q[15:0] != 16'h0 && acc_sum >= unit_s;

   // Trigger condition and handling
   wire alm_c = |(alm_s2_q & amask_q);
   wire din_c = |(din_s2_q & dmask_q);
   wire cond = (mode == trl_pkg::M_ALM) ? alm_c : (mode == trl_pkg::M_DIN) ? din_c : 1'b0;
   wire rise = cond & ~cond_q;
   wire rtp_hit = (rtp == trl_pkg::R_INTV) ? tick.intv :
                  (rtp == trl_pkg::R_MIN)  ? tick.min :
                  (rtp == trl_pkg::R_HOUR) ? tick.hour :
                  (rtp == trl_pkg::R_DAY)  ? tick.day :
                  (rtp == trl_pkg::R_WEEK) ? tick.week :
                  (rtp == trl_pkg::R_MON)  ? tick.month : tick.year;
   wire trg_fire = (hand == trl_pkg::H_EVT) ? rise :
                   (hand == trl_pkg::H_DUR) ? per_hit & durc_q != 16'h0 :
                   (hand == trl_pkg::H_LVL) ? per_hit & cond :
                   per_hit & latch_q;
   wire fire = (mode == trl_pkg::M_RTP) ? rtp_hit :
               (mode == trl_pkg::M_PER) ? per_hit :
               (mode == trl_pkg::M_MAN) ? man_q :
               (mode == trl_pkg::M_ALM || mode == trl_pkg::M_DIN) ? trg_fire : 1'b0;
   wire stopped = full_q & ~wrap;
   wire start = st_q == trl_pkg::S_IDLE && pend_q && !sec_used_q && !stopped;
   wire rec_end = st_q == trl_pkg::S_DONE;

   // Field reduction select
   wire trl_pkg::func_type fn = trl_pkg::func_type'(fcfg_q[fld_q][1:0]);
   wire [16:0] rem_sh = {rem_q[15:0], quo_q[47]};
   wire        rem_ge = rem_sh >= {1'b0, cnt_q[fld_q]};
   wire [31:0] pick = (fn == trl_pkg::F_MAX) ? max_q[fld_q] :
                      (fn == trl_pkg::F_MIN) ? min_q[fld_q] : last_q[fld_q];

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         trl_pkg::S_IDLE: if (start) st_d = trl_pkg::S_LOAD;
         trl_pkg::S_LOAD: st_d = (fn == trl_pkg::F_AVG && cnt_q[fld_q] != 16'h0) ? trl_pkg::S_DIV : trl_pkg::S_OUT;
         trl_pkg::S_DIV:  if (step_q == 6'h1) st_d = trl_pkg::S_OUT;
         trl_pkg::S_OUT:  if (rec_ready) st_d = (fld_q == rsz - 5'h1) ? trl_pkg::S_DONE : trl_pkg::S_LOAD;
         trl_pkg::S_DONE: st_d = trl_pkg::S_IDLE;
         default:         st_d = trl_pkg::S_IDLE;
      endcase
   end

   // AXI4-Lite slave
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         rsp_q <= '0;
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= 8'h0;
         wd_q  <= 32'h0;
         ws_q  <= 4'h0;
      end
      else
      begin
         rsp_q.awready <= ~aw_q;
         rsp_q.wready  <= ~w_q;
         if (axi_req.awvalid & rsp_q.awready)
         begin
            aw_q  <= 1'b1;
            awa_q <= axi_req.awaddr;
            rsp_q.awready <= 1'b0;
         end
         if (axi_req.wvalid & rsp_q.wready)
         begin
            w_q  <= 1'b1;
            wd_q <= axi_req.wdata;
            ws_q <= axi_req.wstrb;
            rsp_q.wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            rsp_q.bvalid <= 1'b1;
            rsp_q.bresp  <= wr_ok ? `TRL_RESP_OK : `TRL_RESP_ERR;
         end
         else if (rsp_q.bvalid & axi_req.bready)
            rsp_q.bvalid <= 1'b0;
         rsp_q.arready <= ~rsp_q.rvalid & ~rd_go;
         if (rd_go)
         begin
            rsp_q.rvalid <= 1'b1;
            rsp_q.rresp  <= `TRL_RESP_OK;
            case (axi_req.araddr)
               `TRL_A_CTRL:  rsp_q.rdata <= ctrl_q;
               `TRL_A_RATE:  rsp_q.rdata <= rate_q;
               `TRL_A_AMASK: rsp_q.rdata <= amask_q;
               `TRL_A_DMASK: rsp_q.rdata <= {26'h0, dmask_q};
               `TRL_A_DUR:   rsp_q.rdata <= dur_q;
               `TRL_A_STAT:  rsp_q.rdata <= stat_w;
               `TRL_A_WPTR:  rsp_q.rdata <= {11'h0, wptr_q};
               default:
               begin
                  rsp_q.rdata <= fsel_r ? {28'h0, fcfg_q[fidx_r]} : 32'h0;
                  rsp_q.rresp <= fsel_r ? `TRL_RESP_OK : `TRL_RESP_ERR;
               end
            endcase
         end
         else if (rsp_q.rvalid & axi_req.rready)
            rsp_q.rvalid <= 1'b0;
      end
   end

   // Register writes; bits 16 and 17 of control are self-clearing pulses
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         ctrl_q  <= `TRL_CTRL_RST;
         rate_q  <= 32'h0;
         amask_q <= 32'h0;
         dmask_q <= 6'h0;
         dur_q   <= 32'h0;
         man_q   <= 1'b0;
         rel_q   <= 1'b0;
      end
      else
      begin
         man_q <= wr_go && awa_q == `TRL_A_CTRL && wval_ctrl[16];
         rel_q <= wr_go && awa_q == `TRL_A_CTRL && wval_ctrl[17];
         if (wr_go)
            case (awa_q)
               `TRL_A_CTRL:  ctrl_q  <= {16'h0, wval_ctrl[15:0]};
               `TRL_A_RATE:  rate_q  <= ((rate_q & ~wmask) | (wd_q & wmask)) & 32'h0003_ffff;
               `TRL_A_AMASK: amask_q <= (amask_q & ~wmask) | (wd_q & wmask);
               `TRL_A_DMASK: if (ws_q[0]) dmask_q <= wd_q[5:0];
               `TRL_A_DUR:   dur_q   <= ((dur_q & ~wmask) | (wd_q & wmask)) & 32'h0000_ffff;
               default:      ;
            endcase
      end
   end

   // Pin synchronisers
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         alm_s1_q <= 32'h0;
         alm_s2_q <= 32'h0;
         din_s1_q <= 6'h0;
         din_s2_q <= 6'h0;
      end
      else
      begin
         alm_s1_q <= alarm_in;
         alm_s2_q <= alm_s1_q;
         din_s1_q <= din_in;
         din_s2_q <= din_s1_q;
      end
   end

   // Trigger state; a set always wins over a clear in the same cycle
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         cond_q     <= 1'b0;
         pend_q     <= 1'b0;
         sec_used_q <= 1'b0;
         latch_q    <= 1'b0;
         durc_q     <= 16'h0;
         acc_q      <= 18'h0;
      end
      else
      begin
         cond_q     <= cond;
         pend_q     <= fire | (pend_q & ~start);
         sec_used_q <= start | (sec_used_q & ~tick.sec);
         latch_q    <= (rise & hand == trl_pkg::H_LAT) | (latch_q & ~rel_q & mode != trl_pkg::M_OFF);
         if (rise & hand == trl_pkg::H_DUR)
            durc_q <= dur_q[15:0];
         else if (tick.sec && durc_q != 16'h0)
            durc_q <= durc_q - 16'h1;
         if (tick.sec)
            acc_q <= per_hit ? ((acc_left >= unit_s) ? 18'h0 : acc_left) : acc_sum;
      end
   end

   // Per-field accumulators; samples are refused while a record is emitted
   for (genvar i = 0; i < 19; i++)
   begin : g_fld
      wire [1:0] wt  = fcfg_q[i][3:2];
      wire       wok = (wt == 2'h0) || (wt == 2'h1 && smp.flow1) || (wt == 2'h2 && smp.flow2);
      wire       hit = smp.valid && rdy_q && smp.field == 5'(i) && wok;
      always_ff @(posedge mclk)
      begin
         if (!resetn || rec_end)
         begin
            sum_q[i] <= 48'h0;
            cnt_q[i] <= 16'h0;
            max_q[i] <= 32'h0;
            min_q[i] <= 32'hffff_ffff;
         end
         else if (hit && cnt_q[i] != 16'hffff)
         begin
            sum_q[i] <= sum_q[i] + {16'h0, smp.value};
            cnt_q[i] <= cnt_q[i] + 16'h1;
            if (smp.value > max_q[i]) max_q[i] <= smp.value;
            if (smp.value < min_q[i]) min_q[i] <= smp.value;
         end
      end
      always_ff @(posedge mclk)
      begin
         if (!resetn)
         begin
            fcfg_q[i] <= 4'h0;
            last_q[i] <= 32'h0;
         end
         else
         begin
            if (wr_go && fsel_w && fidx_w == 5'(i) && ws_q[0])
               fcfg_q[i] <= wd_q[3:0];
            if (hit)
               last_q[i] <= smp.value;
         end
      end
   end

   // Record emission: one field per beat, averages by a serial divider
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         st_q   <= trl_pkg::S_IDLE;
         rec_q  <= '0;
         fld_q  <= 5'h0;
         step_q <= 6'h0;
         rem_q  <= 17'h0;
         quo_q  <= 48'h0;
         wptr_q <= 21'h0;
         full_q <= 1'b0;
         rdy_q  <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         rdy_q <= st_d == trl_pkg::S_IDLE;
         case (st_q)
            trl_pkg::S_IDLE:
               fld_q <= 5'h0;
            trl_pkg::S_LOAD:
            begin
               rem_q  <= 17'h0;
               quo_q  <= sum_q[fld_q];
               step_q <= `TRL_DIV_N;
               if (st_d == trl_pkg::S_OUT)
               begin
                  rec_q.valid <= 1'b1;
                  rec_q.data  <= (fn == trl_pkg::F_AVG) ? 32'h0 : pick;
               end
            end
            trl_pkg::S_DIV:
            begin
               rem_q  <= rem_ge ? 17'(rem_sh - {1'b0, cnt_q[fld_q]}) : rem_sh;
               quo_q  <= {quo_q[46:0], rem_ge};
               step_q <= step_q - 6'h1;
               if (step_q == 6'h1)
               begin
                  rec_q.valid <= 1'b1;
                  rec_q.data  <= {quo_q[30:0], rem_ge};
               end
            end
            trl_pkg::S_OUT:
               if (rec_ready)
               begin
                  rec_q.valid <= 1'b0;
                  fld_q <= fld_q + 5'h1;
               end
            trl_pkg::S_DONE:
               if (wptr_q + 21'h1 >= cap)
               begin
                  full_q <= 1'b1;
                  wptr_q <= wrap ? 21'h0 : cap;
               end
               else
                  wptr_q <= wptr_q + 21'h1;
            default: ;
         endcase
         rec_q.index <= wptr_q;
         rec_q.field <= (st_q == trl_pkg::S_OUT && rec_ready) ? 5'(fld_q + 5'h1) : fld_q;
         rec_q.last  <= (st_q == trl_pkg::S_OUT && rec_ready) ? 1'b0 : fld_q == rsz - 5'h1;
      end
   end

   assign axi_rsp   = rsp_q;
   assign rec       = rec_q;
   assign smp_ready = rdy_q;
   assign log_full  = full_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_rec_done;
      st_q == trl_pkg::S_DONE;
   endsequence
   property p_size;
      rec_q.valid |-> rec_q.field < rsz;
   endproperty
   a_size: assert property (p_size) else $error("field beyond record size");
   property p_rate;
      start |=> (sec_used_q && !start) ##1 (!start || $past(tick.sec));
   endproperty
   a_rate: assert property (p_rate) else $error("second start in one second");
   property p_cap;
      wptr_q <= cap;
   endproperty
   a_cap: assert property (p_cap) else $error("pointer past capacity");
   property p_rtp;
      mode == trl_pkg::M_RTP && rtp == trl_pkg::R_MIN && tick.min |=> pend_q;
   endproperty
   a_rtp: assert property (p_rtp) else $error("minute rollover lost");
   property p_wrap;
      s_rec_done ##0 (wrap && wptr_q + 21'h1 >= cap) |=> wptr_q == 21'h0 && full_q;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not restart");
   property p_stop;
      full_q && !wrap |-> !start;
   endproperty
   a_stop: assert property (p_stop) else $error("write after stop");
   property p_alarm;
      mode == trl_pkg::M_ALM && hand == trl_pkg::H_EVT && !cond_q && |(alm_s2_q & amask_q) |=> pend_q;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm event missed");
   property p_man;
      mode == trl_pkg::M_MAN && man_q |=> pend_q;
   endproperty
   a_man: assert property (p_man) else $error("manual request lost");
   property p_adv;
      s_rec_done ##0 (wptr_q + 21'h1 < cap) |=> wptr_q == $past(wptr_q) + 21'h1;
   endproperty
   a_adv: assert property (p_adv) else $error("pointer not advanced");
   property p_latch;
      rel_q && !(rise && hand == trl_pkg::H_LAT) |=> !latch_q;
   endproperty
   a_latch: assert property (p_latch) else $error("latch not released");
endmodule : triggered_record_logger
`default_nettype wire

// ---- rtl/trl_defs.svh ----
`ifndef TRL_DEFS_SVH
`define TRL_DEFS_SVH
`define TRL_A_CTRL   8'h00
`define TRL_A_RATE   8'h04
`define TRL_A_AMASK  8'h08
`define TRL_A_DMASK  8'h0c
`define TRL_A_DUR    8'h10
`define TRL_A_STAT   8'h14
`define TRL_A_WPTR   8'h18
`define TRL_A_FCFG   8'h40
`define TRL_NFLD     5'h13
`define TRL_NDIN     6
`define TRL_CAP_MAX  1350000
`define TRL_CAP_STEP 67500
`define TRL_DIV_N    6'h30
`define TRL_SEC_S    18'h00001
`define TRL_SEC_M    18'h0003c
`define TRL_SEC_H    18'h00e10
`define TRL_SEC_D    18'h15180
`define TRL_CTRL_RST 32'h0000_0060
`define TRL_RESP_OK  2'h0
`define TRL_RESP_ERR 2'h2
`endif

// ---- rtl/trl_pkg.sv ----
`default_nettype none
package trl_pkg;
   typedef enum logic [2:0] {M_OFF, M_RTP, M_PER, M_ALM, M_DIN, M_MAN} mode_type;
   typedef enum logic [1:0] {H_EVT, H_DUR, H_LVL, H_LAT} hand_type;
   typedef enum logic [2:0] {R_INTV, R_MIN, R_HOUR, R_DAY, R_WEEK, R_MON, R_YEAR} rtp_type;
   typedef enum logic [1:0] {F_AVG, F_MAX, F_MIN, F_DEV} func_type;
   typedef enum {S_IDLE, S_LOAD, S_DIV, S_OUT, S_DONE} state_type;
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_type;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_type;
   typedef struct packed {
      logic sec;
      logic intv;
      logic min;
      logic hour;
      logic day;
      logic week;
      logic month;
      logic year;
   } tick_type;
   typedef struct packed {
      logic        valid;
      logic [4:0]  field;
      logic [31:0] value;
      logic        flow1;
      logic        flow2;
   } smp_type;
   typedef struct packed {
      logic        valid;
      logic [20:0] index;
      logic [4:0]  field;
      logic [31:0] data;
      logic        last;
   } rec_type;
endpackage : trl_pkg
`default_nettype wire
